// *** hdl/sch_consts.svh ***
`ifndef SCH_CONSTS_SVH
`define SCH_CONSTS_SVH

// ==========================================================================
// packet framing
// ==========================================================================
`define SCH_PKT_CMD          8'hC0   // command and response packet type
`define SCH_PKT_EVT          8'h80   // event packet type
`define SCH_GRP_SYS          8'h02   // system command group

// command identifiers inside the system group
`define SCH_ID_PING          8'h01
`define SCH_ID_RESTART       8'h02
`define SCH_ID_DUMP          8'h03
`define SCH_ID_PERSIST       8'h04
`define SCH_ID_RESTORE       8'h05

// event identifiers inside the system group
`define SCH_EVT_BOOT         8'h01
`define SCH_EVT_RESTORED     8'h03
`define SCH_EVT_CHUNK        8'h05

// ==========================================================================
// payload lengths
// ==========================================================================
`define SCH_LEN_EMPTY        8'h00   // no argument bytes
`define SCH_LEN_DUMP_CMD     8'h01   // one selector byte
`define SCH_LEN_RESULT       8'h02   // result code only
`define SCH_LEN_DUMP_RSP     8'h04   // result plus byte count
`define SCH_LEN_PING_RSP     8'h08   // result, seconds, fraction

// text-format response lengths, not used anywhere in this project
`define SCH_TXT_LEN_RESTART  16'h000A
`define SCH_TXT_LEN_DUMP     16'h0012
`define SCH_TXT_LEN_PERSIST  16'h000B

// ==========================================================================
// result codes
// ==========================================================================
`define SCH_RES_OK           16'h0000
`define SCH_RES_UNRECOG      16'h0203
`define SCH_RES_BADLEN       16'h020A
`define SCH_RES_BADVAL       16'h020C

// ==========================================================================
// dump sizes
// ==========================================================================
`define SCH_DUMP_SEL_MAX     8'h03
`define SCH_DUMP_SEL_STATE   8'h03
`define SCH_DUMP_CFG_BYTES   16'h02A2
`define SCH_DUMP_STATE_BYTES 16'h07A3
`define SCH_CHUNK_MAX        16

// ==========================================================================
// timing
// ==========================================================================
`define SCH_OSC_TICKS        32768   // oscillator ticks per second
`define SCH_CLK_PERIOD_NS    4
`define SCH_RESTART_NS       1000    // restart pulse width
`define SCH_RESTART_CYCLES   ((`SCH_RESTART_NS + `SCH_CLK_PERIOD_NS - 1) / `SCH_CLK_PERIOD_NS)

`endif

// *** hdl/sch_pkg.sv ***
package sch_pkg;

	// ======================================================================
	// carriers
	// ======================================================================
	// one decoded command as the framer hands it over
	typedef struct packed {
		logic [7:0] ptype;   // packet type
		logic [7:0] plen;    // payload length
		logic [7:0] group;   // command group
		logic [7:0] id;      // command identifier
		logic [7:0] arg;     // first payload byte, if any
	} sch_cmd_type;

	// header of an outgoing packet
	typedef struct packed {
		logic [7:0] ptype;
		logic [7:0] plen;
		logic [7:0] group;
		logic [7:0] id;
	} sch_hdr_type;

	// ======================================================================
	// sequencer states
	// ======================================================================
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_SEND,
		SEQ_PERSIST,
		SEQ_LOAD,
		SEQ_DRAIN,
		SEQ_RESTART
	} sch_state_type;

	// what follows the packet now being sent
	typedef enum logic [1:0] {
		AFT_NONE,
		AFT_CHUNK,
		AFT_LOAD,
		AFT_RESTART
	} sch_after_type;

endpackage

// *** hdl/sch_byte_fifo.sv ***
`timescale 1ns/100ps
module sch_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	// ======================================================================
	// elaboration checks
	// ======================================================================
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("depth must be a power of two, at least 2");
	end
	if (WIDTH < 1) begin : g_bad_width
		$error("width must be positive");
	end

	logic [WIDTH-1:0] mem [DEPTH];      // storage words
	logic [AW-1:0]    wrPtr_reg;        // next slot to fill
	logic [AW-1:0]    rdPtr_reg;        // oldest word
	logic [AW:0]      count_reg;        // words held
	logic             push;
	logic             pop;

	// full and empty come straight from the count, so they never lie
	assign inReady  = (count_reg != (AW + 1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem[rdPtr_reg];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// pointers and count
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= wrPtr_reg + AW'(push);
			rdPtr_reg <= rdPtr_reg + AW'(pop);
			count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	// storage has no reset; only counted words are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	a_fifo_bound: assert property (@(posedge clk) disable iff (sys_rst)
		(count_reg == (AW + 1)'(DEPTH)) |-> !inReady ##1 (count_reg <= (AW + 1)'(DEPTH)))
		else $error("fifo count passed its depth");

endmodule // sch_byte_fifo

// *** hdl/sch_runtime_clock.sv ***
`timescale 1ns/100ps
`include "sch_consts.svh"
module sch_runtime_clock (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        oscLevel,
	input  wire logic        clear,
	output logic      [31:0] seconds,
	output logic      [15:0] fraction
);
	localparam logic [14:0] FRAC_LAST = 15'(`SCH_OSC_TICKS - 1);

	logic        oscPrev_reg;   // last oscillator level
	logic [31:0] sec_reg;       // whole seconds since boot
	logic [14:0] frac_reg;      // ticks within the second
	logic        tick;
	logic        wrap;

	// each rising oscillator edge is one 1/32768 s step
	assign tick     = oscLevel && !oscPrev_reg;
	assign wrap     = tick && (frac_reg == FRAC_LAST);
	assign seconds  = sec_reg;
	assign fraction = {1'b0, frac_reg};

	// free running; nothing from the host is needed to keep it going
	always_ff @(posedge clk) begin
		if (sys_rst || clear) begin
			oscPrev_reg <= oscLevel;   // a level already high at restart is no new tick
			sec_reg     <= '0;
			frac_reg    <= '0;
		end else begin
			oscPrev_reg <= oscLevel;
			frac_reg    <= wrap ? '0 : frac_reg + 15'(tick);
			sec_reg     <= sec_reg + 32'(wrap);
		end
	end

	a_second_wrap: assert property (@(posedge clk) disable iff (sys_rst || clear)
		wrap |=> (frac_reg == '0) && (sec_reg == $past(sec_reg) + 32'd1))
		else $error("runtime second did not carry");

endmodule // sch_runtime_clock

// *** hdl/sch_system_cmd.sv ***
// How it works
// - liveness query C0/02/01, response length 08
// - response holds seconds, then 1/32768 fraction
// - runtime counted from the 32768 Hz oscillator
// - liveness query answered at once, well formed
// - no periodic query needed to stay alive
// - restart immediate, unsaved runtime settings revert
// - restart drops every link without closing exchange
// - startup event once restart finishes
// - dump selector 0 to 3 picks image
// - dump count 674 config, 1955 state
// - chunk events of at most 16 bytes
// - dump takes one byte, answers four bytes
// - persist copies runtime settings into boot area
// - restore loads factory area then restarts, id 05
// - defaults-restored event first, startup event after
// - restart, persist, restore: empty command, result reply
// - result code right after the header
`timescale 1ns/100ps
`include "sch_consts.svh"
module sch_system_cmd #(
	parameter int FIFO_DEPTH = 8,
	parameter int CHUNK_MAX  = `SCH_CHUNK_MAX
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                cmdValid,
	input  wire sch_pkg::sch_cmd_type cmdIn,
	output logic                     cmdReady,
	input  wire logic                oscLevel,
	output logic                     txValid,
	output logic               [7:0] txData,
	input  wire logic                txReady,
	output logic               [1:0] dumpSel,
	output logic              [10:0] dumpAddr,
	input  wire logic          [7:0] dumpData,
	output logic                     persistReq,
	input  wire logic                persistDone,
	output logic                     factoryLoadReq,
	input  wire logic                factoryDone,
	output logic                     sysRestart
);
	import sch_pkg::*;

	// ======================================================================
	// elaboration checks
	if (CHUNK_MAX < 1 || CHUNK_MAX > 16) begin : g_bad_chunk
		$error("chunk size must be 1 to 16");
	end
	localparam logic [7:0] RST_LAST = 8'(`SCH_RESTART_CYCLES - 1);
	localparam logic [4:0] CHUNK_W  = 5'(CHUNK_MAX);

	// ======================================================================
	// helpers
	// byte i of the packet being sent; chunk events take data from the dump port
	function automatic logic [7:0] pickByte(sch_hdr_type h, logic [63:0] b,
		logic ch, logic [4:0] i, logic [7:0] d);
		logic [4:0] k;
		k = i - 5'd4;
		if (i == 5'd0) return h.ptype;
		if (i == 5'd1) return h.plen;
		if (i == 5'd2) return h.group;
		if (i == 5'd3) return h.id;
		if (ch && i == 5'd4) return h.plen - 8'd1;
		if (ch) return d;
		return b[{k[2:0], 3'b000} +: 8];
	endfunction
	// the next chunk never exceeds the chunk size nor what is left
	function automatic logic [4:0] chunkOf(logic [15:0] left);
		return (left > 16'(CHUNK_W)) ? CHUNK_W : left[4:0];
	endfunction

	// ======================================================================
	// state
	sch_state_type state_reg, state_next;   // sequencer
	sch_after_type after_reg, after_next;   // follow-up of current packet
	sch_hdr_type   hdr_reg, hdr_next;       // header being sent
	logic   [63:0] body_reg, body_next;     // payload, byte 0 in low bits
	logic          chunk_reg, chunk_next;   // packet is a chunk event
	logic    [4:0] idx_reg, idx_next;       // byte position in packet
	logic   [15:0] remain_reg, remain_next; // dump bytes not yet queued
	logic   [10:0] addr_reg, addr_next;     // dump read address
	logic    [1:0] sel_reg, sel_next;       // dump image selector
	logic    [7:0] rstCnt_reg, rstCnt_next; // restart pulse length
	logic          cmdReady_reg;
	logic          persistReq_reg;
	logic          factoryReq_reg;
	logic          sysRestart_reg;

	// ======================================================================
	// decoding
	wire        take     = cmdValid && cmdReady_reg;
	wire        isSys    = (cmdIn.ptype == `SCH_PKT_CMD) && (cmdIn.group == `SCH_GRP_SYS);
	wire        known    = isSys && (cmdIn.id >= `SCH_ID_PING) && (cmdIn.id <= `SCH_ID_RESTORE);
	wire        isDump   = cmdIn.id == `SCH_ID_DUMP;
	wire  [7:0] expLen   = isDump ? `SCH_LEN_DUMP_CMD : `SCH_LEN_EMPTY;
	wire        lenOk    = cmdIn.plen == expLen;
	wire        selOk    = cmdIn.arg <= `SCH_DUMP_SEL_MAX;
	wire [15:0] result   = !known ? `SCH_RES_UNRECOG :
	                       !lenOk ? `SCH_RES_BADLEN :
	                       (isDump && !selOk) ? `SCH_RES_BADVAL : `SCH_RES_OK;
	wire        cmdOk    = result == `SCH_RES_OK;
	wire [15:0] dumpSize = (cmdIn.arg == `SCH_DUMP_SEL_STATE) ?
	                       `SCH_DUMP_STATE_BYTES : `SCH_DUMP_CFG_BYTES;
	wire [31:0] seconds;
	wire [15:0] fraction;
	wire  [7:0] curByte  = pickByte(hdr_reg, body_reg, chunk_reg, idx_reg, dumpData);
	wire  [4:0] lastIdx  = 5'(hdr_reg.plen + 8'd3);
	wire        fifoInValid = state_reg == SEQ_SEND;
	wire        fifoInReady;
	wire        fifoOutValid;
	wire        pushed   = fifoInValid && fifoInReady;
	wire        endPkt   = pushed && (idx_reg == lastIdx);
	wire  [4:0] nextLen  = chunkOf(remain_reg);
	// runtime since boot; restarted with the device
	sch_runtime_clock u_runtime (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.oscLevel (oscLevel),
		.clear    (sysRestart_reg),
		.seconds  (seconds),
		.fraction (fraction)
	);
	// outgoing bytes wait here; a slow host stalls the sequencer
	sch_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.inValid  (fifoInValid),
		.inData   (curByte),
		.inReady  (fifoInReady),
		.outValid (fifoOutValid),
		.outData  (txData),
		.outReady (txReady)
	);
	// ======================================================================
	// sequencer
	always_comb begin
		state_next  = state_reg;
		after_next  = after_reg;
		hdr_next    = hdr_reg;
		body_next   = body_reg;
		chunk_next  = chunk_reg;
		idx_next    = idx_reg;
		remain_next = remain_reg;
		addr_next   = addr_reg;
		sel_next    = sel_reg;
		rstCnt_next = rstCnt_reg;
		unique case (state_reg)
			SEQ_IDLE: begin
				if (take) begin
					// every answer opens with the result code
					hdr_next   = '{`SCH_PKT_CMD, `SCH_LEN_RESULT, cmdIn.group, cmdIn.id};
					body_next  = {48'h0, result};
					chunk_next = 1'b0;
					idx_next   = '0;
					after_next = AFT_NONE;
					state_next = SEQ_SEND;
					if (cmdOk) begin
						unique case (cmdIn.id)
							`SCH_ID_PING: begin
								hdr_next.plen = `SCH_LEN_PING_RSP;
								body_next = {fraction, seconds, result};
							end
							`SCH_ID_RESTART: begin
								after_next = AFT_RESTART;
							end
							`SCH_ID_DUMP: begin
								hdr_next.plen = `SCH_LEN_DUMP_RSP;
								body_next   = {32'h0, dumpSize, result};
								sel_next    = cmdIn.arg[1:0];
								remain_next = dumpSize;
								addr_next   = '0;
								after_next  = AFT_CHUNK;
							end
							`SCH_ID_PERSIST: begin
								state_next = SEQ_PERSIST;
							end
							default: begin
								after_next = AFT_LOAD;
							end
						endcase
					end
				end
			end
			SEQ_SEND: begin
				if (pushed) begin
					idx_next = idx_reg + 5'd1;
					if (chunk_reg && idx_reg > 5'd4) begin
						addr_next = addr_reg + 11'd1;
					end
				end
				if (endPkt) begin
					idx_next   = '0;
					state_next = SEQ_IDLE;
					unique case (after_reg)
						AFT_NONE: begin
						end
						AFT_CHUNK: begin
							// chunks continue until the count is used up
							if (remain_reg != '0) begin
								hdr_next    = '{`SCH_PKT_EVT, 8'(nextLen) + 8'd1,
								                `SCH_GRP_SYS, `SCH_EVT_CHUNK};
								chunk_next  = 1'b1;
								remain_next = remain_reg - 16'(nextLen);
								state_next  = SEQ_SEND;
							end
						end
						AFT_LOAD: begin
							state_next = SEQ_LOAD;
						end
						AFT_RESTART: begin
							state_next = SEQ_DRAIN;
						end
					endcase
				end
			end
			SEQ_PERSIST: begin
				if (persistDone) begin
					state_next = SEQ_SEND;
				end
			end
			SEQ_LOAD: begin
				if (factoryDone) begin
					hdr_next   = '{`SCH_PKT_EVT, `SCH_LEN_EMPTY,
					               `SCH_GRP_SYS, `SCH_EVT_RESTORED};
					after_next = AFT_RESTART;
					state_next = SEQ_SEND;
				end
			end
			SEQ_DRAIN: begin
				// the host must hold the whole answer before we restart
				if (!fifoOutValid) begin
					rstCnt_next = '0;
					state_next  = SEQ_RESTART;
				end
			end
			SEQ_RESTART: begin
				rstCnt_next = rstCnt_reg + 8'd1;
				if (rstCnt_reg == RST_LAST) begin
					hdr_next   = '{`SCH_PKT_EVT, `SCH_LEN_EMPTY,
					               `SCH_GRP_SYS, `SCH_EVT_BOOT};
					chunk_next = 1'b0;
					after_next = AFT_NONE;
					idx_next   = '0;
					state_next = SEQ_SEND;
				end
			end
		endcase
	end
	// sequencer registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg  <= SEQ_IDLE;
			after_reg  <= AFT_NONE;
			hdr_reg    <= '0;
			body_reg   <= '0;
			chunk_reg  <= 1'b0;
			idx_reg    <= '0;
			remain_reg <= '0;
			addr_reg   <= '0;
			sel_reg    <= '0;
			rstCnt_reg <= '0;
		end else begin
			state_reg  <= state_next;
			after_reg  <= after_next;
			hdr_reg    <= hdr_next;
			body_reg   <= body_next;
			chunk_reg  <= chunk_next;
			idx_reg    <= idx_next;
			remain_reg <= remain_next;
			addr_reg   <= addr_next;
			sel_reg    <= sel_next;
			rstCnt_reg <= rstCnt_next;
		end
	end
	// strobes toward the rest of the device, all registered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmdReady_reg   <= 1'b0;
			persistReq_reg <= 1'b0;
			factoryReq_reg <= 1'b0;
			sysRestart_reg <= 1'b0;
		end else begin
			cmdReady_reg   <= state_next == SEQ_IDLE;
			persistReq_reg <= state_next == SEQ_PERSIST;
			factoryReq_reg <= state_next == SEQ_LOAD;
			// restart drops links abruptly and reverts unsaved settings
			sysRestart_reg <= state_next == SEQ_RESTART;
		end
	end
	assign cmdReady       = cmdReady_reg;
	assign txValid        = fifoOutValid;
	assign dumpSel        = sel_reg;
	assign dumpAddr       = addr_reg;
	assign persistReq     = persistReq_reg;
	assign factoryLoadReq = factoryReq_reg;
	assign sysRestart     = sysRestart_reg;
	// ======================================================================
	// checks
	a_ping_length: assert property (@(posedge clk) disable iff (sys_rst)
		take && cmdOk && cmdIn.id == `SCH_ID_PING |=>
		state_reg == SEQ_SEND && hdr_reg.plen == 8'h08 && hdr_reg.ptype == 8'hC0)
		else $error("ping answer header wrong");
	a_dump_total: assert property (@(posedge clk) disable iff (sys_rst)
		take && cmdOk && isDump && cmdIn.arg == 8'h03 |=>
		remain_reg == 16'h07A3 && body_reg[31:16] == 16'h07A3)
		else $error("state dump count wrong");
	a_chunk_size: assert property (@(posedge clk) disable iff (sys_rst)
		state_reg == SEQ_SEND && chunk_reg |-> hdr_reg.plen <= 8'd17 && hdr_reg.plen >= 8'd2)
		else $error("chunk event too long");
	a_result_first: assert property (@(posedge clk) disable iff (sys_rst)
		pushed && idx_reg == 5'd4 && hdr_reg.ptype == 8'hC0 |->
		curByte == body_reg[7:0] ##1 (idx_reg == 5'd5 && curByte == body_reg[15:8]))
		else $error("result code not first in payload");
	a_restart_answer: assert property (@(posedge clk) disable iff (sys_rst)
		take && cmdOk && cmdIn.id == `SCH_ID_RESTART |=>
		hdr_reg.plen == 8'h02 && after_reg == AFT_RESTART)
		else $error("restart answer wrong");
	a_drained_first: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(sysRestart_reg) |-> !fifoOutValid && $past(state_reg) == SEQ_DRAIN)
		else $error("restart before answer left");
	a_boot_follows: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(sysRestart_reg) |-> state_reg == SEQ_SEND && hdr_reg.id == 8'h01 &&
		hdr_reg.ptype == `SCH_PKT_EVT)
		else $error("no startup event after restart");
	a_persist_answer: assert property (@(posedge clk) disable iff (sys_rst)
		persistReq_reg && persistDone |=> state_reg == SEQ_SEND && !persistReq_reg &&
		hdr_reg.id == 8'h04)
		else $error("persist answer missing");
	a_restored_event: assert property (@(posedge clk) disable iff (sys_rst)
		state_reg == SEQ_LOAD && factoryDone |=> hdr_reg.id == 8'h03 &&
		after_reg == AFT_RESTART && !factoryReq_reg)
		else $error("restored event out of order");
endmodule // sch_system_cmd

// *** verif/sch_store_model.sv ***
`timescale 1ns/100ps
// ====================================
// storage and image model at the far side of the command block
module sch_store_model #(
	parameter int DELAY = 5
) (
	input  wire logic        clk,
	input  wire logic [1:0]  dumpSel,
	input  wire logic [10:0] dumpAddr,
	output logic      [7:0]  dumpData,
	input  wire logic        persistReq,
	output logic             persistDone = 1'b0,
	input  wire logic        factoryLoadReq,
	output logic             factoryDone = 1'b0
);
	int waitCnt = 0; // cycles the pending request has waited
	// image byte depends on selector and address, so a wrong image shows
	assign dumpData = dumpAddr[7:0] ^ {4{dumpSel}} ^ {5'h00, dumpAddr[10:8]};
	// storage answers late on purpose, one-cycle done
	always @(posedge clk) begin
		waitCnt <= (persistReq || factoryLoadReq) && !persistDone && !factoryDone ? waitCnt + 1 : 0;
		persistDone <= persistReq && waitCnt == DELAY;
		factoryDone <= factoryLoadReq && waitCnt == DELAY;
	end
endmodule // sch_store_model

// *** verif/system_command_handler_tb.sv ***
`timescale 1ns/100ps
module system_command_handler_tb;
	import sch_pkg::*;
	// ====================================
	// nets and bookkeeping
	logic        clk = 0;
	logic        sys_rst = 1;
	logic        cmdValid = 0;
	logic        oscLevel = 0;
	logic        txReady = 0;
	sch_cmd_type cmdIn = '0;
	logic        cmdReady, txValid, persistReq, persistDone, factoryLoadReq, factoryDone;
	logic        sysRestart;
	logic [7:0]  txData, dumpData;
	logic [1:0]  dumpSel;
	logic [10:0] dumpAddr;
	int          fails = 0, total_checks = 0, cycles = 0, pulse = 0, stores = 0, atRst = 0;
	logic [7:0]  got[$], want[$];

	sch_system_cmd sch_system_cmd_i (.clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid),
		.cmdIn(cmdIn), .cmdReady(cmdReady), .oscLevel(oscLevel), .txValid(txValid),
		.txData(txData), .txReady(txReady), .dumpSel(dumpSel), .dumpAddr(dumpAddr),
		.dumpData(dumpData), .persistReq(persistReq), .persistDone(persistDone),
		.factoryLoadReq(factoryLoadReq), .factoryDone(factoryDone), .sysRestart(sysRestart));
	sch_store_model sch_store_model_i (.clk(clk), .dumpSel(dumpSel), .dumpAddr(dumpAddr),
		.dumpData(dumpData), .persistReq(persistReq), .persistDone(persistDone),
		.factoryLoadReq(factoryLoadReq), .factoryDone(factoryDone));

	always #2 clk = ~clk;
	// host stalls at random so the fifo fills up
	always @(negedge clk) txReady <= ($urandom % 4) != 0;
	// collect taken bytes, measure restart and storage requests, cut a hang
	always @(posedge clk) begin
		if (txValid && txReady) got.push_back(txData);
		if (sysRestart && pulse == 0) atRst = got.size();
		if (sysRestart) pulse++;
		if (persistReq || factoryLoadReq) stores++;
		if (++cycles == 40000) begin
			fails++;
			close_out();
		end
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ====================================
	// expected packets, built from the protocol alone
	task hdr(input logic [7:0] t, input logic [7:0] l, input logic [7:0] i);
		want = {want, t, l, 8'h02, i};
	endtask

	task res(input logic [15:0] r);
		want = {want, r[7:0], r[15:8]};
	endtask

	task dump_exp(input logic [1:0] sel);
		int total, n;
		total = (sel == 2'd3) ? 1955 : 674;
		hdr(8'hC0, 8'h04, 8'h03);
		res(16'h0000);
		want = {want, 8'(total), 8'(total >> 8)};
		for (int a = 0; a < total; a += 16) begin
			n = (total - a < 16) ? total - a : 16;
			hdr(8'h80, 8'(n + 1), 8'h05);
			want.push_back(8'(n));
			for (int b = a; b < a + n; b++) want.push_back(8'(b) ^ {4{sel}} ^ {5'h00, 3'(b >> 8)});
		end
	endtask

	// offer a command until taken, then compare the whole reply stream
	task run(input string name, input logic [7:0] ln, input logic [7:0] id, input logic [7:0] arg);
		int n;
		n = 0;
		@(negedge clk);
		cmdIn = '{8'hC0, ln, 8'h02, id, arg};
		cmdValid = 1;
		while (cmdReady !== 1'b1 && n++ < 100) @(negedge clk);
		@(negedge clk);
		cmdValid = 0;
		n = 0;
		while ((got.size() < want.size() || cmdReady !== 1'b1) && n++ < 10000) @(negedge clk);
		check({name, " size"}, got.size(), want.size());
		foreach (want[k]) check(name, got[k], want[k]);
		$display("test %s done", name);
		got.delete();
		want.delete();
	endtask

	// ====================================
	// main sequence
	initial begin
		void'($urandom(32'ha2be_ddb2));
		repeat (16) @(negedge clk);
		sys_rst = 0;
		// five oscillator ticks, then the query must read them back
		repeat (10) begin
			repeat (4) @(negedge clk);
			oscLevel = ~oscLevel;
		end
		hdr(8'hC0, 8'h08, 8'h01);
		res(16'h0000);
		want = {want, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00};
		run("ping", 8'h00, 8'h01, 8'h00);
		for (int s = 0; s < 4; s++) begin
			dump_exp(2'(s));
			run("dump", 8'h01, 8'h03, 8'(s));
		end
		hdr(8'hC0, 8'h02, 8'h07);
		res(16'h0203);
		run("bad id", 8'h00, 8'h07, 8'h00);
		hdr(8'hC0, 8'h02, 8'h01);
		res(16'h020A);
		run("bad length", 8'h01, 8'h01, 8'h00);
		hdr(8'hC0, 8'h02, 8'h03);
		res(16'h020C);
		run("bad selector", 8'h01, 8'h03, 8'h04);
		hdr(8'hC0, 8'h02, 8'h04);
		res(16'h0000);
		stores = 0;
		// persist is issued only while the bench holds no link open
		run("persist", 8'h00, 8'h04, 8'h00);
		check("persist request", stores > 0, 1);
		hdr(8'hC0, 8'h02, 8'h02);
		res(16'h0000);
		hdr(8'h80, 8'h00, 8'h01);
		pulse = 0;
		run("restart", 8'h00, 8'h02, 8'h00);
		check("restart pulse", pulse, 250);
		check("bytes before restart", atRst, 6);
		hdr(8'hC0, 8'h02, 8'h05);
		res(16'h0000);
		hdr(8'h80, 8'h00, 8'h03);
		hdr(8'h80, 8'h00, 8'h01);
		pulse = 0;
		stores = 0;
		// bench host already runs the factory transport, so nothing to switch back
		run("restore", 8'h00, 8'h05, 8'h00);
		check("restore pulse", pulse, 250);
		check("restore bytes before restart", atRst, 10);
		check("factory request", stores > 0, 1);
		close_out();
	end
endmodule // system_command_handler_tb
